// ---- design/ovl_pkg.sv ----
// shared constants and types of the output voltage limit monitor
package ovl_pkg;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR     = 8'h03;
	localparam logic [7:0] CMD_OV_RESP   = 8'h41;
	localparam logic [7:0] CMD_HI_WARN   = 8'h42;
	localparam logic [7:0] CMD_LO_WARN   = 8'h43;
	localparam logic [7:0] CMD_LO_FAULT  = 8'h44;
	localparam logic [7:0] CMD_UV_RESP   = 8'h45;
	localparam logic [7:0] CMD_STATUS    = 8'h7a;

	// ------------------------------------------------------------
	// reset values, percentages in tenths of a percent
	// ------------------------------------------------------------
	localparam logic [15:0] RST_HI_WARN  = 16'h0438;
	localparam logic [15:0] RST_LO_WARN  = 16'h0398;
	localparam logic [15:0] RST_LO_FAULT = 16'h0320;
	localparam logic [7:0]  RST_OV_RESP  = 8'h80;
	localparam logic [7:0]  RST_UV_RESP  = 8'h80;

	// ------------------------------------------------------------
	// hardware percentage grids
	// ------------------------------------------------------------
	localparam logic [31:0] PCT_SCALE    = 32'h000003e8;
	localparam logic [15:0] HI_BASE      = 16'h0406;
	localparam logic [15:0] HI_TOP       = 16'h0488;
	localparam logic [15:0] LO_BASE      = 16'h0348;
	localparam logic [15:0] LO_TOP       = 16'h03ca;
	localparam logic [15:0] UVF_BASE     = 16'h0258;
	localparam logic [15:0] UVF_TOP      = 16'h03b6;
	localparam logic [15:0] STEP_1PCT    = 16'h000a;
	localparam logic [15:0] STEP_2P5PCT  = 16'h0019;
	localparam logic [4:0]  WARN_STEPS   = 5'h0e;
	localparam logic [4:0]  UVF_STEPS    = 5'h0f;

	// ------------------------------------------------------------
	// fault action byte layout and codes
	// ------------------------------------------------------------
	localparam int          ACT_HI       = 7;
	localparam int          ACT_LO       = 6;
	localparam int          RETRY_HI     = 5;
	localparam int          RETRY_LO     = 3;
	localparam int          DLY_HI       = 2;
	localparam int          DLY_LO       = 0;
	localparam logic [1:0]  ACT_IGNORE   = 2'h0;
	localparam logic [1:0]  ACT_DELAYED  = 2'h1;
	localparam logic [1:0]  ACT_NOW      = 2'h2;
	localparam logic [1:0]  ACT_BAD      = 2'h3;
	localparam logic [2:0]  RETRY_ALWAYS = 3'h7;
	localparam logic [2:0]  DLY_SHORT    = 3'h1;
	localparam logic [2:0]  DLY_MID      = 3'h3;
	localparam logic [2:0]  DLY_LONG     = 3'h7;
	localparam logic [2:0]  DLY_SEL_MID  = 3'h2;
	localparam logic [2:0]  DLY_SEL_LONG = 3'h5;
	localparam logic [23:0] TMO_OFF      = 24'h000000;

	// ------------------------------------------------------------
	// status bit positions
	// ------------------------------------------------------------
	localparam int          SB_HI_WARN   = 0;
	localparam int          SB_LO_WARN   = 1;
	localparam int          SB_LO_FAULT  = 2;
	localparam int          SB_OV_FAULT  = 3;
	localparam int          SB_INVALID   = 4;
	localparam int          SB_VOUT      = 5;
	localparam int          SB_REFUSED   = 6;
	localparam int          SB_W         = 7;

	typedef enum logic [2:0] {
		S_OFF     = 3'b000,
		S_RISE    = 3'b001,
		S_OBSERVE = 3'b010,
		S_RUN     = 3'b011,
		S_HICCUP  = 3'b100,
		S_LATCHED = 3'b101
	} ovl_state_t;

endpackage

// ---- design/ovl_limit_cmp.sv ----
// relative threshold comparator against the present setpoint
`timescale 1ns/1ps
module ovl_limit_cmp
	import ovl_pkg::*;
(
	input  logic [15:0] sense,
	input  logic [15:0] setpoint,
	input  logic [15:0] pct,
	output logic        above,
	output logic        below
);
	logic [31:0] sense_scaled;
	logic [31:0] limit_scaled;

	// scaling both sides avoids a divider
	assign sense_scaled = 32'(sense) * PCT_SCALE;
	assign limit_scaled = 32'(setpoint) * 32'(pct);
	assign above        = sense_scaled > limit_scaled;
	assign below        = sense_scaled < limit_scaled;
endmodule

// ---- design/ovl_monitor.sv ----
// output voltage limit monitor: limit commands, warnings, start-up
`timescale 1ns/1ps
module ovl_monitor
	import ovl_pkg::*;
(
	input  logic        sys_clk,
	input  logic        nrst,
	input  logic        cmd_wr,
	input  logic        cmd_rd,
	input  logic [7:0]  cmd_code,
	input  logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic        cmd_ack,
	input  logic        output_value_format,
	input  logic [15:0] output_setpoint,
	input  logic [15:0] vout_sense,
	input  logic        overvoltage_fault_event,
	input  logic        conv_enable,
	input  logic [23:0] soft_start_rise_time,
	input  logic [23:0] rise_timeout_limit,
	input  logic        pwm_tick,
	output logic        status_word_vout,
	output logic        high_warning_flag,
	output logic        low_warning_flag,
	output logic        low_fault_flag,
	output logic        invalid_data_flag,
	output logic        start_refused,
	output logic        host_alert,
	output logic        converter_run,
	output logic [2:0]  restart_count
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		ovl_state_t      state;
		logic [15:0]     hi_raw;
		logic [15:0]     lo_raw;
		logic [15:0]     uvf_raw;
		logic [15:0]     hi_pct;
		logic [15:0]     lo_pct;
		logic [15:0]     uvf_pct;
		logic [7:0]      ov_resp;
		logic [7:0]      uv_resp;
		logic [SB_W-1:0] status;
		logic            alert;
		logic [15:0]     rdata;
		logic            ack;
		logic [23:0]     tcnt;
		logic [2:0]      restarts;
		logic [2:0]      dly_cnt;
		logic            run;
	} ovl_regs_t;

	localparam ovl_regs_t RST_REGS = '{
		state:   S_OFF,
		hi_raw:  RST_HI_WARN,
		lo_raw:  RST_LO_WARN,
		uvf_raw: RST_LO_FAULT,
		hi_pct:  RST_HI_WARN,
		lo_pct:  RST_LO_WARN,
		uvf_pct: RST_LO_FAULT,
		ov_resp: RST_OV_RESP,
		uv_resp: RST_UV_RESP,
		default: '0
	};

	ovl_regs_t       r;
	ovl_regs_t       n;
	logic [16:0]     m_hi;
	logic [16:0]     m_lo;
	logic [16:0]     m_uvf;
	logic            hi_above;
	logic            lo_below;
	logic            uvf_below;
	logic            low_armed;
	logic [1:0]      uv_act;
	logic [2:0]      dly_lim;
	logic            uv_fire;
	logic            ov_shut;
	logic            shut;
	logic [2:0]      retry_lim;
	logic [23:0]     window;
	logic [23:0]     tcnt_inc;
	logic            bad;
	logic            clr;
	logic [SB_W-1:0] set_v;

	// ------------------------------------------------------------
	// percentage mapping
	// ------------------------------------------------------------
	// result is {valid, percentage}; valid only inside the grid
	function automatic logic [16:0] map_pct(
		input logic [15:0] val,
		input logic        absf,
		input logic [15:0] sp,
		input logic [15:0] base,
		input logic [15:0] step,
		input logic [4:0]  cnt,
		input logic        up
	);
		logic [31:0] lhs;
		logic [31:0] rhs;
		logic [15:0] p;
		logic [15:0] best;
		logic        any_le;
		logic        any_ge;
		lhs    = absf ? 32'(val) * PCT_SCALE : 32'(val);
		best   = '0;
		any_le = 1'b0;
		any_ge = 1'b0;
		for (int i = 0; i < 16; i++) begin
			p   = base + 16'(i) * step;
			rhs = absf ? 32'(sp) * 32'(p) : 32'(p);
			if (i < int'(cnt)) begin
				if (up && !any_ge && rhs >= lhs) begin
					best = p;
				end
				if (!up && rhs <= lhs) begin
					best = p;
				end
				any_le = any_le | (rhs <= lhs);
				any_ge = any_ge | (rhs >= lhs);
			end
		end
		return {any_le & any_ge, best};
	endfunction

	assign m_hi  = map_pct(cmd_wdata, output_value_format,
		output_setpoint, HI_BASE, STEP_1PCT, WARN_STEPS, 1'b1);
	assign m_lo  = map_pct(cmd_wdata, output_value_format,
		output_setpoint, LO_BASE, STEP_1PCT, WARN_STEPS, 1'b0);
	assign m_uvf = map_pct(cmd_wdata, output_value_format,
		output_setpoint, UVF_BASE, STEP_2P5PCT, UVF_STEPS, 1'b0);

	// ------------------------------------------------------------
	// comparators on the present setpoint
	// ------------------------------------------------------------
	// stored percentages never move with the setpoint; limits do
	ovl_limit_cmp u_hi (
		.sense    (vout_sense),
		.setpoint (output_setpoint),
		.pct      (r.hi_pct),
		.above    (hi_above),
		.below    ()
	);
	ovl_limit_cmp u_lo (
		.sense    (vout_sense),
		.setpoint (output_setpoint),
		.pct      (r.lo_pct),
		.above    (),
		.below    (lo_below)
	);
	ovl_limit_cmp u_uvf (
		.sense    (vout_sense),
		.setpoint (output_setpoint),
		.pct      (r.uvf_pct),
		.above    (),
		.below    (uvf_below)
	);

	// ------------------------------------------------------------
	// fault decisions
	// ------------------------------------------------------------
	// low side means nothing while the output ramps or is off
	assign low_armed = r.run && (r.state != S_RISE);
	assign uv_act    = r.uv_resp[ACT_HI:ACT_LO];
	assign dly_lim   = (r.uv_resp[DLY_HI:DLY_LO] < DLY_SEL_MID) ?
		DLY_SHORT : (r.uv_resp[DLY_HI:DLY_LO] < DLY_SEL_LONG) ?
		DLY_MID : DLY_LONG;
	assign uv_fire   = low_armed && uvf_below &&
		((uv_act == ACT_NOW) ||
		 (uv_act == ACT_DELAYED && r.dly_cnt == dly_lim));
	assign ov_shut   = overvoltage_fault_event &&
		(r.ov_resp[ACT_HI:ACT_LO] != ACT_IGNORE);
	assign shut      = r.run && (uv_fire || ov_shut);
	assign retry_lim = uv_fire ? r.uv_resp[RETRY_HI:RETRY_LO] :
		r.ov_resp[RETRY_HI:RETRY_LO];
	assign window    = (rise_timeout_limit != TMO_OFF) ?
		rise_timeout_limit : soft_start_rise_time;
	assign tcnt_inc  = r.tcnt + 24'h000001;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n     = r;
		n.ack = 1'b0;
		bad   = 1'b0;
		clr   = 1'b0;

		// command writes; rejected words leave the register alone
		if (cmd_wr) begin
			case (cmd_code)
				CMD_HI_WARN: begin
					if (m_hi[16]) begin
						n.hi_raw = cmd_wdata;
						n.hi_pct = m_hi[15:0];
					end else begin
						bad = 1'b1;
					end
				end
				CMD_LO_WARN: begin
					if (m_lo[16]) begin
						n.lo_raw = cmd_wdata;
						n.lo_pct = m_lo[15:0];
					end else begin
						bad = 1'b1;
					end
				end
				CMD_LO_FAULT: begin
					if (m_uvf[16]) begin
						n.uvf_raw = cmd_wdata;
						n.uvf_pct = m_uvf[15:0];
					end else begin
						bad = 1'b1;
					end
				end
				CMD_OV_RESP: begin
					if (cmd_wdata[ACT_HI:ACT_LO] != ACT_BAD) begin
						n.ov_resp = cmd_wdata[7:0];
					end else begin
						bad = 1'b1;
					end
				end
				CMD_UV_RESP: begin
					if (cmd_wdata[ACT_HI:ACT_LO] != ACT_BAD) begin
						n.uv_resp = cmd_wdata[7:0];
					end else begin
						bad = 1'b1;
					end
				end
				CMD_CLEAR: begin
					clr = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// command reads answer one cycle later
		if (cmd_rd) begin
			n.ack = 1'b1;
			case (cmd_code)
				CMD_HI_WARN:  n.rdata = r.hi_raw;
				CMD_LO_WARN:  n.rdata = r.lo_raw;
				CMD_LO_FAULT: n.rdata = r.uvf_raw;
				CMD_OV_RESP:  n.rdata = {8'h00, r.ov_resp};
				CMD_UV_RESP:  n.rdata = {8'h00, r.uv_resp};
				CMD_STATUS:   n.rdata = {9'h000, r.status};
				default:      n.rdata = 16'h0000;
			endcase
		end

		// undervoltage shutdown delay in pwm clocks
		if (!(low_armed && uvf_below)) begin
			n.dly_cnt = 3'h0;
		end else if (pwm_tick && r.dly_cnt != dly_lim) begin
			n.dly_cnt = r.dly_cnt + 3'h1;
		end

		// sticky events; set beats a clear in the same cycle
		set_v              = '0;
		set_v[SB_HI_WARN]  = hi_above;
		set_v[SB_LO_WARN]  = low_armed && lo_below;
		set_v[SB_LO_FAULT] = low_armed && uvf_below;
		set_v[SB_OV_FAULT] = overvoltage_fault_event;
		set_v[SB_INVALID]  = bad;
		set_v[SB_VOUT]     = hi_above || (low_armed &&
			(lo_below || uvf_below)) || overvoltage_fault_event;

		// start-up and restart sequencing
		case (r.state)
			S_OFF: begin
				n.run = 1'b0;
				if (conv_enable) begin
					if (overvoltage_fault_event) begin
						set_v[SB_REFUSED] = 1'b1;
					end else begin
						n.state = S_RISE;
						n.tcnt  = 24'h000000;
						n.run   = 1'b1;
					end
				end
			end
			S_RISE: begin
				n.tcnt = tcnt_inc;
				if (tcnt_inc >= window) begin
					n.state = S_OBSERVE;
					n.tcnt  = 24'h000000;
				end
			end
			S_OBSERVE: begin
				n.tcnt = tcnt_inc;
				if (tcnt_inc >= soft_start_rise_time) begin
					n.state    = S_RUN;
					n.restarts = 3'h0;
				end
			end
			S_RUN: begin
			end
			S_HICCUP: begin
				n.tcnt = tcnt_inc;
				if (tcnt_inc >= soft_start_rise_time) begin
					n.state    = S_RISE;
					n.tcnt     = 24'h000000;
					n.run      = 1'b1;
					if (r.restarts != RETRY_ALWAYS) begin
						n.restarts = r.restarts + 3'h1;
					end
				end
			end
			S_LATCHED: begin
				n.run = 1'b0;
			end
			default: begin
				n.state = S_OFF;
				n.run   = 1'b0;
			end
		endcase

		// a shutdown fault in any live state ends the attempt
		if (shut) begin
			n.run  = 1'b0;
			n.tcnt = 24'h000000;
			if (retry_lim == RETRY_ALWAYS || r.restarts < retry_lim) begin
				n.state = S_HICCUP;
			end else begin
				n.state = S_LATCHED;
			end
		end

		// commanded off releases a latch and forgets attempts
		if (!conv_enable) begin
			n.state    = S_OFF;
			n.run      = 1'b0;
			n.tcnt     = 24'h000000;
			n.restarts = 3'h0;
		end

		n.status = (clr ? '0 : r.status) | set_v;
		n.alert  = |n.status;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= RST_REGS;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_rdata         = r.rdata;
	assign cmd_ack           = r.ack;
	assign status_word_vout  = r.status[SB_VOUT];
	assign high_warning_flag = r.status[SB_HI_WARN];
	assign low_warning_flag  = r.status[SB_LO_WARN];
	assign low_fault_flag    = r.status[SB_LO_FAULT];
	assign invalid_data_flag = r.status[SB_INVALID];
	assign start_refused     = r.status[SB_REFUSED];
	assign host_alert        = r.alert;
	assign converter_run     = r.run;
	assign restart_count     = r.restarts;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	property p_bad_hi_write;
		cmd_wr && cmd_code == CMD_HI_WARN && !m_hi[16] |=>
			invalid_data_flag && host_alert && $stable(r.hi_raw);
	endproperty
	a_bad_hi_write: assert property (p_bad_hi_write)
		else $error("invalid high warning write not flagged");

	property p_success_clears;
		(r.state == S_OBSERVE ##1 r.state == S_RUN) |->
			restart_count == 3'h0;
	endproperty
	a_success_clears: assert property (p_success_clears)
		else $error("restart count not cleared on success");

	property p_window_start;
		(r.state == S_RISE ##1 r.state == S_OBSERVE) |->
			$past(tcnt_inc) == $past(window) &&
			$past(window) == ((rise_timeout_limit != TMO_OFF) ?
			rise_timeout_limit : soft_start_rise_time);
	endproperty
	a_window_start: assert property (p_window_start)
		else $error("observation window started at wrong time");

	property p_refuse;
		r.state == S_OFF && conv_enable && overvoltage_fault_event |=>
			r.state == S_OFF && !converter_run && start_refused;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("started with overvoltage present");

	property p_hi_warn;
		hi_above |=> high_warning_flag && status_word_vout && host_alert;
	endproperty
	a_hi_warn: assert property (p_hi_warn)
		else $error("high warning not reported");

	property p_hi_grid;
		cmd_wr && cmd_code == CMD_HI_WARN && m_hi[16] |=>
			r.hi_pct >= HI_BASE && r.hi_pct <= HI_TOP &&
			(r.hi_pct - HI_BASE) % STEP_1PCT == 16'h0000;
	endproperty
	a_hi_grid: assert property (p_hi_grid)
		else $error("high warning off its grid");

	property p_lo_grid;
		cmd_wr && cmd_code == CMD_LO_WARN && m_lo[16] |=>
			r.lo_pct >= LO_BASE && r.lo_pct <= LO_TOP &&
			(r.lo_pct - LO_BASE) % STEP_1PCT == 16'h0000;
	endproperty
	a_lo_grid: assert property (p_lo_grid)
		else $error("low warning off its grid");

	property p_uv_now;
		r.state == S_RUN && conv_enable && uvf_below &&
			uv_act == ACT_NOW |=> !converter_run;
	endproperty
	a_uv_now: assert property (p_uv_now)
		else $error("undervoltage action not taken");

	property p_ignore;
		r.state == S_RUN && conv_enable && !uv_fire &&
			r.ov_resp[ACT_HI:ACT_LO] == ACT_IGNORE |=>
			r.state == S_RUN && converter_run;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ignored fault interrupted operation");

	property p_sticky;
		low_warning_flag && !(cmd_wr && cmd_code == CMD_CLEAR) |=>
			low_warning_flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("warning flag lost without clear");

	c_run: cover property (r.state == S_OBSERVE ##1 r.state == S_RUN);
	c_refused: cover property (r.state == S_OFF && conv_enable &&
		overvoltage_fault_event);
	c_latched: cover property (r.state == S_LATCHED);
	c_bad: cover property (cmd_wr && !m_uvf[16] &&
		cmd_code == CMD_LO_FAULT);

endmodule

// ---- bench/ovl_host.sv ----
// host model driving the monitor command port
`timescale 1ns/1ps
module ovl_host (
	input  logic        sys_clk,
	output logic        cmd_wr,
	output logic        cmd_rd,
	output logic [7:0]  cmd_code,
	output logic [15:0] cmd_wdata,
	input  logic [15:0] cmd_rdata,
	input  logic        cmd_ack
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// released lines never keep the last value, so a late sample shows up
	task automatic write_cmd(input logic [7:0] c, input logic [15:0] d);
		cmd_code = c;
		cmd_wdata = d;
		cmd_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_wr = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
		// idle edge: a following call never re-raises a line in this step
		@(posedge sys_clk);
		#1;
	endtask

	task automatic read_cmd(input logic [7:0] c, output logic [15:0] d);
		int n;
		cmd_code = c;
		cmd_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_rd = 1'b0;
		cmd_code = ~c;
		n = 0;
		while (cmd_ack !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		d = (cmd_ack === 1'b1) ? cmd_rdata : 16'hxxxx;
		@(posedge sys_clk);
		#1;
	endtask
endmodule

// ---- bench/test_output_voltage_limit_monitor.sv ----
// self-checking bench of the output voltage limit monitor
`timescale 1ns/1ps
module test_output_voltage_limit_monitor
	import ovl_pkg::*;
;
	logic        sys_clk, nrst, fmt, ov, en, pwm_tick;
	logic        cmd_wr, cmd_rd, cmd_ack;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, sp, sense, rv, t;
	logic [23:0] rise, tmo;
	logic        sw_vout, hi_f, lo_f, uvf_f, inv_f, refused, alert, run;
	logic [2:0]  rcount;
	logic [31:0] rng;
	int          err_count, tests_run, i;
	logic [7:0]  cds [3] = '{CMD_HI_WARN, CMD_LO_WARN, CMD_LO_FAULT};
	logic [15:0] lob [3] = '{HI_BASE, LO_BASE, UVF_BASE};
	logic [15:0] hib [3] = '{HI_TOP, LO_TOP, UVF_TOP};

	ovl_monitor dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
		.output_value_format(fmt), .output_setpoint(sp),
		.vout_sense(sense), .overvoltage_fault_event(ov),
		.conv_enable(en), .soft_start_rise_time(rise),
		.rise_timeout_limit(tmo), .pwm_tick(pwm_tick),
		.status_word_vout(sw_vout), .high_warning_flag(hi_f),
		.low_warning_flag(lo_f), .low_fault_flag(uvf_f),
		.invalid_data_flag(inv_f), .start_refused(refused),
		.host_alert(alert), .converter_run(run), .restart_count(rcount));

	ovl_host host (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack));

	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) #1 pwm_tick = ~pwm_tick;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// expected grid point of a relative value, rounding up or down
	function automatic logic [15:0] grid(input logic [15:0] p, b, s,
		input logic up);
		logic [15:0] k;
		k = (p - b) / s;
		if (up && ((p - b) % s) != 16'h0000) k++;
		return b + k * s;
	endfunction

	function automatic logic [15:0] thr(input logic [15:0] s, g);
		return 16'((32'(s) * 32'(g)) / PCT_SCALE);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic chk_b(input logic seen, input logic exp);
		check({15'h0000, seen}, {15'h0000, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		host.read_cmd(c, d);
		check(d, exp);
	endtask

	task automatic clear();
		host.write_cmd(CMD_CLEAR, 16'h0000);
		cyc(1);
	endtask

	task automatic done(input int n);
		$display("test %0d done", n);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		fmt = 1'b0;
		sp = 16'h03e8;
		sense = 16'h03e8;
		ov = 1'b0;
		en = 1'b0;
		pwm_tick = 1'b0;
		rise = 24'h000004;
		tmo = 24'h00000c;
		rng = 32'h00000031;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		rd_chk(CMD_HI_WARN, RST_HI_WARN);
		rd_chk(CMD_LO_WARN, RST_LO_WARN);
		rd_chk(CMD_LO_FAULT, RST_LO_FAULT);
		rd_chk(CMD_OV_RESP, {8'h00, RST_OV_RESP});
		rd_chk(CMD_UV_RESP, {8'h00, RST_UV_RESP});
		rd_chk(8'h55, 16'h0000);
		done(1);
		for (i = 0; i < 12; i++) begin
			rng = xs(rng);
			rv = lob[i%3] + 16'(rng % 32'(hib[i%3] - lob[i%3] + 16'h0001));
			host.write_cmd(cds[i%3], rv);
			rd_chk(cds[i%3], rv);
		end
		chk_b(inv_f, 1'b0);
		done(2);
		host.write_cmd(CMD_HI_WARN, 16'h040a);
		host.write_cmd(CMD_HI_WARN, HI_BASE - 16'h0001);
		cyc(1);
		chk_b(inv_f, 1'b1);
		chk_b(alert, 1'b1);
		rd_chk(CMD_HI_WARN, 16'h040a);
		host.read_cmd(CMD_STATUS, rv);
		chk_b(rv[SB_INVALID], 1'b1);
		clear();
		chk_b(inv_f, 1'b0);
		host.write_cmd(CMD_UV_RESP, 16'h00c0);
		cyc(1);
		chk_b(inv_f, 1'b1);
		rd_chk(CMD_UV_RESP, 16'h0080);
		clear();
		done(3);
		t = thr(sp, grid(16'h040a, HI_BASE, STEP_1PCT, 1'b1));
		sense = t;
		cyc(2);
		chk_b(hi_f, 1'b0);
		sense = t + 16'h0001;
		cyc(2);
		chk_b(hi_f, 1'b1);
		chk_b(sw_vout, 1'b1);
		chk_b(alert, 1'b1);
		sense = sp;
		cyc(2);
		chk_b(hi_f, 1'b1);
		clear();
		chk_b(hi_f, 1'b0);
		done(4);
		// absolute value taken at setpoint 1000 means 110.0 percent
		fmt = 1'b1;
		host.write_cmd(CMD_HI_WARN, 16'h044c);
		sp = 16'h07d0;
		sense = sp;
		cyc(2);
		rd_chk(CMD_HI_WARN, 16'h044c);
		t = thr(sp, 16'h044c);
		sense = t;
		cyc(2);
		chk_b(hi_f, 1'b0);
		sense = t + 16'h0001;
		cyc(2);
		chk_b(hi_f, 1'b1);
		fmt = 1'b0;
		sp = 16'h03e8;
		sense = sp;
		clear();
		done(5);
		host.write_cmd(CMD_LO_WARN, 16'h0389);
		host.write_cmd(CMD_LO_FAULT, 16'h0334);
		sense = 16'h0352;
		en = 1'b1;
		cyc(8);
		chk_b(run, 1'b1);
		chk_b(lo_f, 1'b0);
		cyc(12);
		chk_b(lo_f, 1'b1);
		chk_b(sw_vout, 1'b1);
		tmo = 24'h000000;
		t = thr(sp, grid(16'h0389, LO_BASE, STEP_1PCT, 1'b0));
		sense = t;
		clear();
		cyc(2);
		chk_b(lo_f, 1'b0);
		sense = t - 16'h0001;
		cyc(2);
		chk_b(lo_f, 1'b1);
		done(6);
		host.write_cmd(CMD_UV_RESP, 16'h0000);
		t = thr(sp, grid(16'h0334, UVF_BASE, STEP_2P5PCT, 1'b0));
		sense = t;
		cyc(2);
		chk_b(uvf_f, 1'b0);
		sense = t - 16'h0001;
		cyc(4);
		chk_b(run, 1'b1);
		host.write_cmd(CMD_UV_RESP, 16'h00b8);
		cyc(2);
		chk_b(run, 1'b0);
		sense = sp;
		cyc(6);
		check({13'h0000, rcount}, 16'h0001);
		cyc(20);
		check({13'h0000, rcount}, 16'h0000);
		chk_b(run, 1'b1);
		// delayed action with no retries must latch off, count untouched
		host.write_cmd(CMD_UV_RESP, 16'h0041);
		sense = t - 16'h0001;
		cyc(8);
		chk_b(run, 1'b0);
		cyc(20);
		chk_b(run, 1'b0);
		check({13'h0000, rcount}, 16'h0000);
		sense = sp;
		done(7);
		en = 1'b0;
		cyc(2);
		host.write_cmd(CMD_OV_RESP, 16'h0000);
		clear();
		ov = 1'b1;
		en = 1'b1;
		cyc(4);
		chk_b(run, 1'b0);
		chk_b(refused, 1'b1);
		ov = 1'b0;
		cyc(3);
		chk_b(run, 1'b1);
		cyc(10);
		ov = 1'b1;
		cyc(3);
		chk_b(run, 1'b1);
		ov = 1'b0;
		done(8);
		report_and_stop();
	end
endmodule
